/* usc_pkg.sv */
package usc_pkg;
   // register byte addresses
   localparam logic [31:0] USC_A_CTRL = 32'h400e_0600;
   localparam logic [31:0] USC_A_MODE = 32'h400e_0604;
   localparam logic [31:0] USC_A_IEN = 32'h400e_0608;
   localparam logic [31:0] USC_A_IDIS = 32'h400e_060c;
   localparam logic [31:0] USC_A_IMASK = 32'h400e_0610;
   localparam logic [31:0] USC_A_STAT = 32'h400e_0614;
   localparam logic [31:0] USC_A_RHOLD = 32'h400e_0618;
   localparam logic [31:0] USC_A_THOLD = 32'h400e_061c;
   localparam logic [31:0] USC_A_BAUD = 32'h400e_0620;
   localparam logic [31:0] USC_A_CMP = 32'h400e_0624;
   localparam logic [31:0] USC_A_WPROT = 32'h400e_06e4;
   // control command bits
   localparam int USC_C_RXRST = 2;
   localparam int USC_C_TXRST = 3;
   localparam int USC_C_RXEN = 4;
   localparam int USC_C_RXDIS = 5;
   localparam int USC_C_TXEN = 6;
   localparam int USC_C_TXDIS = 7;
   localparam int USC_C_CLRERR = 8;
   localparam int USC_C_REQCLR = 12;
   // status and mask bit positions
   localparam int USC_S_RXAV = 0;
   localparam int USC_S_TXFREE = 1;
   localparam int USC_S_RXDMA = 3;
   localparam int USC_S_TXDMA = 4;
   localparam int USC_S_OVR = 5;
   localparam int USC_S_FRM = 6;
   localparam int USC_S_PAR = 7;
   localparam int USC_S_TXIDLE = 9;
   localparam int USC_S_TX_DMA_BUFFER_EMPTY = 11;
   localparam int USC_S_RX_DMA_BUFFER_FULL = 12;
   localparam int USC_S_MATCH = 15;
   localparam logic [31:0] USC_S_VALID = 32'h0000_9afb;
   // field positions
   localparam int USC_F_PAR_LO = 9;
   localparam int USC_F_LOW_LO = 0;
   localparam int USC_F_MODE = 12;
   localparam int USC_F_CHKPAR = 14;
   localparam int USC_F_HIGH_LO = 16;
   localparam int USC_F_KEY_LO = 8;
   localparam logic [23:0] USC_WP_KEY = 24'h55_4152;
   // reset values and frame bit counts
   localparam logic [31:0] USC_R_MASK = 32'h0000_0000;
   localparam logic [15:0] USC_R_BAUD = 16'h0000;
   localparam logic [2:0] USC_R_PAR = 3'h0;
   localparam logic [7:0] USC_R_BYTE = 8'h00;
   localparam logic [3:0] USC_RX_STOP_PAR = 4'ha;
   localparam logic [3:0] USC_TX_BITS = 4'hb;

   // parity bit for a character; modes 4 and up carry no parity
   function automatic logic usc_par_bit(input logic [7:0] d, input logic [2:0] m);
      unique case (m)
         3'h0: usc_par_bit = ^d;
         3'h1: usc_par_bit = ~(^d);
         3'h2: usc_par_bit = 1'b0;
         default: usc_par_bit = 1'b1;
      endcase
   endfunction
endpackage

/* usc_ser_if.sv */
`timescale 1ns/1ps
interface usc_ser_if;
   logic [15:0] divisor;
   logic [2:0] par_mode;
   logic rx_en;
   logic rx_rst;
   logic tx_rst;
   logic tx_en;
   logic tx_valid;
   logic [7:0] tx_data;
   logic tx_take;
   logic tx_busy;
   logic rx_done;
   logic [7:0] rx_data;
   logic rx_par_err;
   logic rx_frm_err;
   modport ctl(output divisor, par_mode, rx_en, rx_rst, tx_rst, tx_en, tx_valid, tx_data,
               input tx_take, tx_busy, rx_done, rx_data, rx_par_err, rx_frm_err);
   modport eng(input divisor, par_mode, rx_en, rx_rst, tx_rst, tx_en, tx_valid, tx_data,
               output tx_take, tx_busy, rx_done, rx_data, rx_par_err, rx_frm_err);
endinterface

/* usc_serial.sv */
`timescale 1ns/1ps
module usc_serial (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic rxd,
   output logic txd,
   usc_ser_if.eng s
);
   logic [15:0] div_cnt_r;
   logic tick;
   logic has_par;
   logic tx_busy_r;
   logic txd_r;
   logic [10:0] tx_sh_r;
   logic [3:0] tx_bits_r;
   logic [3:0] tx_ph_r;
   logic rx_act_r;
   logic [3:0] rx_ph_r;
   logic [3:0] rx_cnt_r;
   logic [7:0] rx_dat_r;
   logic rx_pbit_r;
   logic rx_done_r;
   logic [7:0] rx_out_r;
   logic rx_perr_r;
   logic rx_ferr_r;
   logic [3:0] rx_last;

   // sample tick at clk/divisor, sixteen ticks per bit; divisor 0 stops it
   assign tick = (s.divisor != 16'h0000) && (div_cnt_r == s.divisor - 16'h0001);
   assign has_par = s.par_mode < 3'h4;
   assign rx_last = has_par ? usc_pkg::USC_RX_STOP_PAR : usc_pkg::USC_RX_STOP_PAR - 4'h1;
   // no character leaves while the baud clock is stopped
   assign s.tx_take = ce && s.tx_en && s.tx_valid && !tx_busy_r && !s.tx_rst &&
                      s.divisor != 16'h0000;
   assign s.tx_busy = tx_busy_r;
   assign s.rx_done = rx_done_r;
   assign s.rx_data = rx_out_r;
   assign s.rx_par_err = rx_perr_r;
   assign s.rx_frm_err = rx_ferr_r;
   assign txd = txd_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_r <= 16'h0000;
      end else if (ce) begin
         if (s.divisor == 16'h0000 || tick) begin
            div_cnt_r <= 16'h0000;
         end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
         end
      end
   end

   // transmitter: start, 8 data, parity (or extra stop), stop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_busy_r <= 1'b0;
         tx_sh_r <= 11'h7ff;
         tx_bits_r <= 4'h0;
         tx_ph_r <= 4'h0;
         txd_r <= 1'b1;
      end else if (ce) begin
         txd_r <= tx_busy_r ? tx_sh_r[0] : 1'b1;
         if (s.tx_rst) begin
            tx_busy_r <= 1'b0;
         end else if (s.tx_take) begin
            tx_sh_r <= {1'b1, has_par ? usc_pkg::usc_par_bit(s.tx_data, s.par_mode) : 1'b1,
                        s.tx_data, 1'b0};
            tx_bits_r <= usc_pkg::USC_TX_BITS;
            tx_ph_r <= 4'h0;
            tx_busy_r <= 1'b1;
         end else if (tx_busy_r && tick) begin
            tx_ph_r <= tx_ph_r + 4'h1;
            if (tx_ph_r == 4'hf) begin
               tx_sh_r <= {1'b1, tx_sh_r[10:1]};
               tx_bits_r <= tx_bits_r - 4'h1;
               if (tx_bits_r == 4'h1) begin
                  tx_busy_r <= 1'b0;
               end
            end
         end
      end
   end

   // receiver: mid-bit sampling at phase 7
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_act_r <= 1'b0;
         rx_ph_r <= 4'h0;
         rx_cnt_r <= 4'h0;
         rx_dat_r <= usc_pkg::USC_R_BYTE;
         rx_pbit_r <= 1'b0;
         rx_done_r <= 1'b0;
         rx_out_r <= usc_pkg::USC_R_BYTE;
         rx_perr_r <= 1'b0;
         rx_ferr_r <= 1'b0;
      end else if (ce) begin
         rx_done_r <= 1'b0;
         if (s.rx_rst) begin
            rx_act_r <= 1'b0;
         end else if (!rx_act_r) begin
            if (tick && s.rx_en && !rxd) begin
               rx_act_r <= 1'b1;
               rx_ph_r <= 4'h1;
               rx_cnt_r <= 4'h0;
            end
         end else if (tick) begin
            rx_ph_r <= rx_ph_r + 4'h1;
            if (rx_ph_r == 4'h7) begin
               rx_cnt_r <= rx_cnt_r + 4'h1;
               if (rx_cnt_r == 4'h0 && rxd) begin
                  rx_act_r <= 1'b0;
               end else if (rx_cnt_r == rx_last) begin
                  rx_act_r <= 1'b0;
                  rx_done_r <= 1'b1;
                  rx_out_r <= rx_dat_r;
                  rx_ferr_r <= !rxd;
                  rx_perr_r <= has_par &&
                               (rx_pbit_r != usc_pkg::usc_par_bit(rx_dat_r, s.par_mode));
               end else if (rx_cnt_r == 4'h9) begin
                  rx_pbit_r <= rxd;
               end else if (rx_cnt_r != 4'h0) begin
                  rx_dat_r <= {rxd, rx_dat_r[7:1]};
               end
            end
         end
      end
   end
endmodule

/* uart_status_compare_regs.sv */
// Strobed register access was decided locally.
`timescale 1ns/1ps
module uart_status_compare_regs (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic rxd,
   output logic txd,
   input wire logic rx_dma_end,
   input wire logic tx_dma_end,
   input wire logic tx_dma_buf_empty,
   input wire logic rx_dma_buf_full,
   input wire logic wake_enable,
   output logic wake_req,
   output logic irq
);
   logic rst_meta_r;
   logic rst_n_r;
   logic [31:0] rdata_r;
   logic [31:0] mask_r;
   logic [2:0] par_mode_r;
   logic [15:0] baud_divisor_r;
   logic [7:0] range_low_r;
   logic [7:0] range_high_r;
   logic match_mode_r;
   logic match_checks_parity_r;
   logic write_lock_enable_r;
   logic rx_en_r;
   logic tx_en_r;
   logic rx_char_available_r;
   logic [7:0] received_char_r;
   logic thr_full_r;
   logic [7:0] char_to_send_r;
   logic overrun_flag_r;
   logic frame_error_flag_r;
   logic parity_error_flag_r;
   logic match_flag_r;
   logic trig_r;
   logic wake_r;
   logic irq_r;
   logic [3:0] dma_r;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_ien;
   logic wr_idis;
   logic wr_thold;
   logic wr_baud;
   logic wr_cmp;
   logic wr_wprot;
   logic rd_rhold;
   logic clr_err;
   logic req_clr;
   logic match_now;
   logic rx_load;
   logic [31:0] status;
   logic [31:0] rd_mux;

   usc_ser_if ser ();

   // reset release through two flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   function automatic logic in_range(input logic [7:0] c, input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (c >= lo) && (c <= hi);
   endfunction

   // write decode; protected registers ignore writes while locked
   assign wr_ctrl = wr && addr == usc_pkg::USC_A_CTRL;
   assign wr_mode = wr && addr == usc_pkg::USC_A_MODE && !write_lock_enable_r;
   assign wr_ien = wr && addr == usc_pkg::USC_A_IEN;
   assign wr_idis = wr && addr == usc_pkg::USC_A_IDIS;
   assign wr_thold = wr && addr == usc_pkg::USC_A_THOLD;
   assign wr_baud = wr && addr == usc_pkg::USC_A_BAUD && !write_lock_enable_r;
   assign wr_cmp = wr && addr == usc_pkg::USC_A_CMP && !write_lock_enable_r;
   assign wr_wprot = wr && addr == usc_pkg::USC_A_WPROT &&
                     wdata[31:usc_pkg::USC_F_KEY_LO] == usc_pkg::USC_WP_KEY;
   assign rd_rhold = rd && addr == usc_pkg::USC_A_RHOLD;
   assign clr_err = wr_ctrl && wdata[usc_pkg::USC_C_CLRERR];
   assign req_clr = wr_ctrl && wdata[usc_pkg::USC_C_REQCLR];

   // comparison on the arriving character
   assign match_now = in_range(ser.rx_data, range_low_r, range_high_r) &&
                      !(match_checks_parity_r && ser.rx_par_err);
   assign rx_load = ser.rx_done && (!match_mode_r || trig_r || match_now);

   assign ser.divisor = baud_divisor_r;
   assign ser.par_mode = par_mode_r;
   assign ser.rx_en = rx_en_r;
   assign ser.tx_en = tx_en_r;
   assign ser.rx_rst = wr_ctrl && wdata[usc_pkg::USC_C_RXRST];
   assign ser.tx_rst = wr_ctrl && wdata[usc_pkg::USC_C_TXRST];
   assign ser.tx_valid = thr_full_r;
   assign ser.tx_data = char_to_send_r;

   usc_serial u_serial (
      .clk(clk),
      .rst_n(rst_n_r),
      .ce(ce),
      .rxd(rxd),
      .txd(txd),
      .s(ser)
   );

   always_comb begin
      status = 32'h0000_0000;
      status[usc_pkg::USC_S_RXAV] = rx_char_available_r;
      status[usc_pkg::USC_S_TXFREE] = tx_en_r && !thr_full_r;
      status[usc_pkg::USC_S_RXDMA] = dma_r[0];
      status[usc_pkg::USC_S_TXDMA] = dma_r[1];
      status[usc_pkg::USC_S_OVR] = overrun_flag_r;
      status[usc_pkg::USC_S_FRM] = frame_error_flag_r;
      status[usc_pkg::USC_S_PAR] = parity_error_flag_r;
      status[usc_pkg::USC_S_TXIDLE] = tx_en_r && !thr_full_r && !ser.tx_busy;
      status[usc_pkg::USC_S_TX_DMA_BUFFER_EMPTY] = dma_r[2];
      status[usc_pkg::USC_S_RX_DMA_BUFFER_FULL] = dma_r[3];
      status[usc_pkg::USC_S_MATCH] = match_flag_r;
   end

   // dma channel signals, sampled once
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         dma_r <= 4'h0;
      end else if (ce) begin
         dma_r <= {rx_dma_buf_full, tx_dma_buf_empty, tx_dma_end, rx_dma_end};
      end
   end

   // interrupt mask: set via enable, clear via disable
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mask_r <= usc_pkg::USC_R_MASK;
      end else if (ce) begin
         if (wr_ien) begin
            mask_r <= mask_r | (wdata & usc_pkg::USC_S_VALID);
         end else if (wr_idis) begin
            mask_r <= mask_r & ~(wdata & usc_pkg::USC_S_VALID);
         end
      end
   end

   // receiver enable; disable wins over enable
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rx_en_r <= 1'b0;
      end else if (ce && wr_ctrl) begin
         if (wdata[usc_pkg::USC_C_RXRST] || wdata[usc_pkg::USC_C_RXDIS]) begin
            rx_en_r <= 1'b0;
         end else if (wdata[usc_pkg::USC_C_RXEN]) begin
            rx_en_r <= 1'b1;
         end
      end
   end

   // transmitter enable
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tx_en_r <= 1'b0;
      end else if (ce && wr_ctrl) begin
         if (wdata[usc_pkg::USC_C_TXRST] || wdata[usc_pkg::USC_C_TXDIS]) begin
            tx_en_r <= 1'b0;
         end else if (wdata[usc_pkg::USC_C_TXEN]) begin
            tx_en_r <= 1'b1;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         par_mode_r <= usc_pkg::USC_R_PAR;
         baud_divisor_r <= usc_pkg::USC_R_BAUD;
         range_low_r <= usc_pkg::USC_R_BYTE;
         range_high_r <= usc_pkg::USC_R_BYTE;
         match_mode_r <= 1'b0;
         match_checks_parity_r <= 1'b0;
      end else if (ce) begin
         if (wr_mode) begin
            par_mode_r <= wdata[usc_pkg::USC_F_PAR_LO +: 3];
         end
         if (wr_baud) begin
            baud_divisor_r <= wdata[15:0];
         end
         if (wr_cmp) begin
            range_low_r <= wdata[usc_pkg::USC_F_LOW_LO +: 8];
            range_high_r <= wdata[usc_pkg::USC_F_HIGH_LO +: 8];
            match_mode_r <= wdata[usc_pkg::USC_F_MODE];
            match_checks_parity_r <= wdata[usc_pkg::USC_F_CHKPAR];
         end
      end
   end

   // write protection, keyed
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         write_lock_enable_r <= 1'b0;
      end else if (ce && wr_wprot) begin
         write_lock_enable_r <= wdata[0];
      end
   end

   // receive holding register and its ready flag
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rx_char_available_r <= 1'b0;
         received_char_r <= usc_pkg::USC_R_BYTE;
      end else if (ce) begin
         if (rx_load) begin
            received_char_r <= ser.rx_data;
         end
         // a new character wins over a read in the same cycle
         rx_char_available_r <= rx_load ||
                                (rx_char_available_r && !rd_rhold && rx_en_r);
      end
   end

   // transmit holding register
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         thr_full_r <= 1'b0;
         char_to_send_r <= usc_pkg::USC_R_BYTE;
      end else if (ce) begin
         if (wr_thold) begin
            char_to_send_r <= wdata[7:0];
            thr_full_r <= 1'b1;
         end else if (ser.tx_take || ser.tx_rst) begin
            thr_full_r <= 1'b0;
         end
      end
   end

   // sticky error flags; a new event wins over the clear
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         overrun_flag_r <= 1'b0;
         frame_error_flag_r <= 1'b0;
         parity_error_flag_r <= 1'b0;
      end else if (ce) begin
         overrun_flag_r <= (rx_load && rx_char_available_r && !rd_rhold) ||
                           (overrun_flag_r && !clr_err);
         frame_error_flag_r <= (ser.rx_done && ser.rx_frm_err) ||
                               (frame_error_flag_r && !clr_err);
         parity_error_flag_r <= (ser.rx_done && ser.rx_par_err) ||
                                (parity_error_flag_r && !clr_err);
      end
   end

   // match flag; a new match wins over the clear
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         match_flag_r <= 1'b0;
      end else if (ce) begin
         match_flag_r <= (ser.rx_done && match_now) || (match_flag_r && !clr_err);
      end
   end

   // comparison trigger and wake-up request, both dropped by request clear
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         trig_r <= 1'b0;
      end else if (ce) begin
         trig_r <= (ser.rx_done && match_now) || (trig_r && !req_clr);
      end
   end

   // wake-up request
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wake_r <= 1'b0;
      end else if (ce) begin
         wake_r <= (ser.rx_done && match_now && wake_enable) || (wake_r && !req_clr);
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_r <= 1'b0;
      end else if (ce) begin
         irq_r <= |(status & mask_r);
      end
   end

   always_comb begin
      unique case (addr)
         usc_pkg::USC_A_MODE: rd_mux = {20'h0_0000, par_mode_r, 9'h000};
         usc_pkg::USC_A_IMASK: rd_mux = mask_r;
         usc_pkg::USC_A_STAT: rd_mux = status;
         usc_pkg::USC_A_RHOLD: rd_mux = {24'h00_0000, received_char_r};
         usc_pkg::USC_A_BAUD: rd_mux = {16'h0000, baud_divisor_r};
         usc_pkg::USC_A_CMP: rd_mux = {8'h00, range_high_r, 1'b0, match_checks_parity_r,
                                       1'b0, match_mode_r, 4'h0, range_low_r};
         usc_pkg::USC_A_WPROT: rd_mux = {31'h0000_0000, write_lock_enable_r};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rdata_r <= 32'h0000_0000;
      end else if (ce) begin
         rdata_r <= rd ? rd_mux : 32'h0000_0000;
      end
   end

   assign rdata = rdata_r;
   assign wake_req = wake_r;
   assign irq = irq_r;
endmodule

/* usc_assertions.sv */
`timescale 1ns/1ps
module usc_assertions (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic rx_dma_end,
   input wire logic tx_dma_end,
   input wire logic tx_dma_buf_empty,
   input wire logic rx_dma_buf_full,
   input wire logic wake_enable,
   input wire logic wake_req,
   input wire logic irq
);
   logic [3:0] dma;
   assign dma = {rx_dma_buf_full, tx_dma_buf_empty, tx_dma_end, rx_dma_end};
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_mask_view_bits: assert property (
      $past(rd && addr == usc_pkg::USC_A_IMASK) |-> (rdata & ~usc_pkg::USC_S_VALID) == 32'h0)
      else $error("mask view shows a bit with no source");
   chk_rx_flag_cleared: assert property (
      $past(rd && addr == usc_pkg::USC_A_RHOLD, 3) && $past(rd && addr == usc_pkg::USC_A_STAT)
      |-> !rdata[0]) else $error("character flag still set after holding read");
   chk_dma_end_mirror: assert property (
      $past(rd && addr == usc_pkg::USC_A_STAT) && $past(dma) == $past(dma, 3)
      |-> rdata[4:3] == $past(dma[1:0])) else $error("dma end flags do not follow inputs");
   chk_dma_buf_mirror: assert property (
      $past(rd && addr == usc_pkg::USC_A_STAT) && $past(dma) == $past(dma, 3)
      |-> rdata[12:11] == $past(dma[3:2])) else $error("dma buffer flags do not follow inputs");
   chk_rhold_upper_zero: assert property (
      $past(rd && addr == usc_pkg::USC_A_RHOLD) |-> rdata[31:8] == 24'h0)
      else $error("holding read has upper bits set");
   chk_rdata_one_cycle: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside its cycle");
   chk_wake_needs_enable: assert property ($rose(wake_req) |-> $past(wake_enable))
      else $error("wake request without wake enable");
   chk_idis_kills_irq: assert property (
      wr && addr == usc_pkg::USC_A_IDIS && wdata == 32'hffff_ffff |-> ##3 !irq)
      else $error("interrupt stays up after all sources disabled");
   chk_key_reads_zero: assert property (
      $past(rd && addr == usc_pkg::USC_A_WPROT) |-> rdata[31:8] == 24'h0)
      else $error("protect key field reads nonzero");
endmodule
bind uart_status_compare_regs usc_assertions u_chk (.clk(clk), .nrst(nrst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_dma_end(rx_dma_end),
   .tx_dma_end(tx_dma_end), .tx_dma_buf_empty(tx_dma_buf_empty),
   .rx_dma_buf_full(rx_dma_buf_full), .wake_enable(wake_enable), .wake_req(wake_req),
   .irq(irq));

/* usc_remote_dev.sv */
`timescale 1ns/1ps
module usc_remote_dev #(parameter int BIT_CLKS = 16) (
   input wire logic clk,
   output logic rxd,
   input wire logic txd
);
   logic [7:0] got [$];
   initial rxd = 1'b1;
   // frame: start, 8 data lsb first, parity slot, stop, then one idle bit
   task automatic send(input logic [7:0] c, input logic pbit, input logic stop);
      logic [10:0] f;
      f = {stop, pbit, c, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd <= f[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk);
   endtask
   initial begin
      logic [7:0] c;
      forever begin
         @(negedge txd);
         repeat (BIT_CLKS / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            c[i] = txd;
         end
         got.push_back(c);
         repeat (2 * BIT_CLKS) @(posedge clk);
      end
   end
endmodule

/* uart_status_compare_regs_tb_top.sv */
`timescale 1ns/1ps
module uart_status_compare_regs_tb_top;
   logic clk, nrst, ce, wr, rd, rxd, txd, wake_req, irq, wake_enable;
   logic rx_dma_end, tx_dma_end, tx_dma_buf_empty, rx_dma_buf_full;
   logic [31:0] addr, wdata, rdata, d;
   int error_cnt, num_checks;
   uart_status_compare_regs dut (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .rx_dma_end(rx_dma_end),
      .tx_dma_end(tx_dma_end), .tx_dma_buf_empty(tx_dma_buf_empty),
      .rx_dma_buf_full(rx_dma_buf_full), .wake_enable(wake_enable), .wake_req(wake_req),
      .irq(irq));
   usc_remote_dev #(.BIT_CLKS(16)) remote (.clk(clk), .rxd(rxd), .txd(txd));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
      check(d & m, e);
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic t_reset_vals;
      rd_chk(usc_pkg::USC_A_IMASK, 32'hffff_ffff, 32'h0000_0000);
      rd_chk(usc_pkg::USC_A_STAT, 32'hffff_ffff, 32'h0000_0000);
      wr_reg(usc_pkg::USC_A_BAUD, 32'h0000_0001);
      wr_reg(usc_pkg::USC_A_CTRL, 32'h0000_0050);
      rd_chk(usc_pkg::USC_A_STAT, 32'h0000_0202, 32'h0000_0202);
   endtask
   task automatic t_dma_irq;
      {rx_dma_buf_full, tx_dma_buf_empty, tx_dma_end, rx_dma_end} <= 4'h5;
      repeat (4) @(posedge clk);
      rd_chk(usc_pkg::USC_A_STAT, 32'h0000_1818, 32'h0000_0808);
      {rx_dma_buf_full, tx_dma_buf_empty, tx_dma_end, rx_dma_end} <= 4'ha;
      repeat (4) @(posedge clk);
      rd_chk(usc_pkg::USC_A_STAT, 32'h0000_1818, 32'h0000_1010);
      wr_reg(usc_pkg::USC_A_IEN, 32'h0000_0010);
      wr_reg(usc_pkg::USC_A_IEN, 32'h0000_0000);
      rd_chk(usc_pkg::USC_A_IMASK, 32'hffff_ffff, 32'h0000_0010);
      check({31'h0, irq}, 32'h1);
      wr_reg(usc_pkg::USC_A_IDIS, 32'hffff_ffff);
      rd_chk(usc_pkg::USC_A_IMASK, 32'hffff_ffff, 32'h0000_0000);
      check({31'h0, irq}, 32'h0);
      {rx_dma_buf_full, tx_dma_buf_empty, tx_dma_end, rx_dma_end} <= 4'h0;
   endtask
   task automatic t_rx;
      remote.send(8'h5a, ^8'h5a, 1'b1);
      rd_chk(usc_pkg::USC_A_STAT, 32'h0000_0001, 32'h0000_0001);
      rd_chk(usc_pkg::USC_A_RHOLD, 32'hffff_ffff, 32'h0000_005a);
      rd_chk(usc_pkg::USC_A_STAT, 32'h0000_0001, 32'h0000_0000);
      remote.send(8'h11, ~^8'h11, 1'b1);
      remote.send(8'h22, ^8'h22, 1'b0);
      repeat (200) @(posedge clk);
      remote.send(8'h33, ^8'h33, 1'b1);
      rd_chk(usc_pkg::USC_A_RHOLD, 32'hffff_ffff, 32'h0000_0033);
      rd_chk(usc_pkg::USC_A_STAT, 32'h0000_00e0, 32'h0000_00e0);
      wr_reg(usc_pkg::USC_A_CTRL, 32'h0000_0100);
      rd_chk(usc_pkg::USC_A_STAT, 32'h0000_80e0, 32'h0000_0000);
   endtask
   task automatic t_compare;
      logic [8:0] tab [6];
      tab = '{9'h02f, 9'h130, 9'h139, 9'h03a, 9'h000, 9'h0ff};
      wake_enable <= 1'b1;
      wr_reg(usc_pkg::USC_A_CMP, 32'h0039_4030);
      for (int i = 0; i < 6; i++) begin
         remote.send(tab[i][7:0], ^tab[i][7:0], 1'b1);
         rd_chk(usc_pkg::USC_A_STAT, 32'h0000_8000, {16'h0, tab[i][8], 15'h0});
         check({31'h0, wake_req}, {31'h0, tab[i][8]});
         wr_reg(usc_pkg::USC_A_CTRL, 32'h0000_1100);
         rd_chk(usc_pkg::USC_A_RHOLD, 32'hffff_ffff, {24'h0, tab[i][7:0]});
      end
      remote.send(8'h35, ~^8'h35, 1'b1);
      rd_chk(usc_pkg::USC_A_STAT, 32'h0000_8080, 32'h0000_0080);
      check({31'h0, wake_req}, 32'h0);
      wr_reg(usc_pkg::USC_A_CMP, 32'h0039_0030);
      remote.send(8'h35, ~^8'h35, 1'b1);
      rd_chk(usc_pkg::USC_A_STAT, 32'h0000_8080, 32'h0000_8080);
      wr_reg(usc_pkg::USC_A_CTRL, 32'h0000_1100);
      rd_chk(usc_pkg::USC_A_STAT, 32'h0000_8000, 32'h0000_0000);
      wake_enable <= 1'b0;
   endtask
   task automatic t_match_mode;
      wr_reg(usc_pkg::USC_A_CMP, 32'h0041_1041);
      wr_reg(usc_pkg::USC_A_CTRL, 32'h0000_1000);
      rd_chk(usc_pkg::USC_A_RHOLD, 32'hffff_ffff, 32'h0000_0035);
      remote.send(8'h20, ^8'h20, 1'b1);
      rd_chk(usc_pkg::USC_A_STAT, 32'h0000_0001, 32'h0000_0000);
      remote.send(8'h41, ^8'h41, 1'b1);
      wr_reg(usc_pkg::USC_A_CTRL, 32'h0000_0020);
      rd_chk(usc_pkg::USC_A_STAT, 32'h0000_0001, 32'h0000_0000);
      rd_chk(usc_pkg::USC_A_RHOLD, 32'hffff_ffff, 32'h0000_0041);
   endtask
   task automatic t_tx;
      wr_reg(usc_pkg::USC_A_THOLD, 32'h0000_00a5);
      wr_reg(usc_pkg::USC_A_THOLD, 32'h0000_003c);
      rd_chk(usc_pkg::USC_A_STAT, 32'h0000_0202, 32'h0000_0000);
      repeat (400) @(posedge clk);
      check(remote.got.size(), 32'h2);
      check({24'h0, remote.got[0]}, 32'h0000_00a5);
      check({24'h0, remote.got[1]}, 32'h0000_003c);
      rd_chk(usc_pkg::USC_A_STAT, 32'h0000_0202, 32'h0000_0202);
   endtask
   task automatic t_lock;
      wr_reg(usc_pkg::USC_A_WPROT, 32'h1234_5601);
      rd_chk(usc_pkg::USC_A_WPROT, 32'hffff_ffff, 32'h0000_0000);
      wr_reg(usc_pkg::USC_A_WPROT, 32'h5541_5201);
      rd_chk(usc_pkg::USC_A_WPROT, 32'hffff_ffff, 32'h0000_0001);
      wr_reg(usc_pkg::USC_A_BAUD, 32'h0000_0007);
      rd_chk(usc_pkg::USC_A_BAUD, 32'hffff_ffff, 32'h0000_0001);
      wr_reg(usc_pkg::USC_A_WPROT, 32'h5541_5200);
      rd_chk(usc_pkg::USC_A_WPROT, 32'hffff_ffff, 32'h0000_0000);
      ce <= 1'b0;
      wr_reg(usc_pkg::USC_A_WPROT, 32'h5541_5201);
      ce <= 1'b1;
      rd_chk(usc_pkg::USC_A_WPROT, 32'hffff_ffff, 32'h0000_0000);
   endtask
   task automatic t_baud_zero;
      int lows;
      lows = 0;
      wr_reg(usc_pkg::USC_A_BAUD, 32'h0000_0000);
      wr_reg(usc_pkg::USC_A_THOLD, 32'h0000_0077);
      repeat (300) begin
         @(posedge clk);
         if (txd !== 1'b1) lows++;
      end
      check(lows, 32'h0);
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #400_000;
      error_cnt++;
      close_out;
   end
   initial begin
      {nrst, wr, rd, wake_enable, addr, wdata} = '0;
      {rx_dma_buf_full, tx_dma_buf_empty, tx_dma_end, rx_dma_end} = 4'h0;
      ce = 1'b1;
      error_cnt = 0;
      num_checks = 0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset_vals;
      t_dma_irq;
      t_rx;
      t_compare;
      t_match_mode;
      t_tx;
      t_lock;
      t_baud_zero;
      close_out;
   end
endmodule
